//--- logic/msr_bank.sv
// Model-specific register bank, cycle counter and breakpoint address registers.
// Assumes the core presents one request per cycle as a one-cycle strobe and
// reads the answer on the cycle after, all on core_clk.
`timescale 1ns/1ps
module msr_bank
  import msr_bank_pkg::*;
#(
  parameter bit low_power = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register instruction request
  input wire msr_req_t msr_req,
  // Counter read instruction request
  input wire logic counter_read_instr,
  input wire logic [1:0] counter_privilege,
  // Control register four bits
  input wire logic [31:0] control_register_four,
  // Debug register request
  input wire dbg_req_t dbg_req,
  // Answers
  output msr_rsp_t msr_rsp,
  output logic [31:0] dbg_rdata,
  output logic dbg_done,
  // Block state
  output logic l1_cache_disable,
  output logic machine_check_exception,
  output logic [63:0] feature_enable_out
);

  logic [63:0] machine_check_address;
  logic [63:0] machine_check_type;
  logic [63:0] cache_disable_test;
  logic [63:0] cycle_counter;
  logic [63:0] feature_enable;
  logic [63:0] syscall_target;
  logic [63:0] write_handling_control;
  logic [63:0] uncached_combining_control;
  logic [63:0] power_mgmt_base;
  logic [63:0] state_observability;
  logic [63:0] page_flush_invalidate;
  logic [63:0] second_level_array_access;
  logic [31:0] breakpoint_addr [4];

  logic [63:0] wr_value;
  logic known;
  logic priv_ok;
  logic bad_reserved;
  logic wr_ok;
  logic [63:0] next_read;

  assign wr_value = {msr_req.high_data, msr_req.low_data};
  assign priv_ok = (msr_req.privilege == 2'b00);

  always_comb begin
    known = 1'b1;
    next_read = reg64_reset;
    case (msr_req.index)
      idx_machine_check_address: next_read = machine_check_address;
      idx_machine_check_type: next_read = machine_check_type;
      idx_cache_disable_test: next_read = cache_disable_test;
      idx_cycle_counter: next_read = cycle_counter;
      idx_feature_enable: next_read = feature_enable & feature_enable_impl_mask;
      idx_syscall_target: next_read = syscall_target;
      idx_write_handling_control: next_read = write_handling_control;
      idx_uncached_combining_control: next_read = uncached_combining_control;
      idx_state_observability: next_read = state_observability;
      idx_page_flush_invalidate: next_read = page_flush_invalidate;
      idx_second_level_array_access: next_read = second_level_array_access;
      idx_power_mgmt_base: begin
        known = low_power;
        next_read = low_power ? power_mgmt_base : reg64_reset;
      end
      default: known = 1'b0;
    endcase
  end

  // reserved feature bits written as one fault
  assign bad_reserved = msr_req.wr && (msr_req.index == idx_feature_enable) &&
                        ((wr_value & ~feature_enable_impl_mask) != reg64_reset);
  // writes need level 0 and a known index
  assign wr_ok = msr_req.wr && known && priv_ok && !bad_reserved;

  // machine-check registers: write or reset only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      machine_check_address <= reg64_reset;
      machine_check_type <= reg64_reset;
    end else if (wr_ok) begin
      if (msr_req.index == idx_machine_check_address) begin
        machine_check_address <= wr_value;
      end
      if (msr_req.index == idx_machine_check_type) begin
        machine_check_type <= wr_value;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cycle_counter <= reg64_reset;
    end else if (wr_ok && msr_req.index == idx_cycle_counter) begin
      cycle_counter <= wr_value;
    end else begin
      cycle_counter <= cycle_counter + 64'h1;
    end
  end

  // Extended and test registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cache_disable_test <= reg64_reset;
      feature_enable <= feature_enable_reset;
      syscall_target <= reg64_reset;
      write_handling_control <= reg64_reset;
      uncached_combining_control <= reg64_reset;
      power_mgmt_base <= reg64_reset;
      state_observability <= reg64_reset;
      page_flush_invalidate <= reg64_reset;
      second_level_array_access <= reg64_reset;
    end else if (wr_ok) begin
      case (msr_req.index)
        idx_cache_disable_test: cache_disable_test <= wr_value;
        idx_feature_enable: feature_enable <= wr_value & feature_enable_impl_mask;
        idx_syscall_target: syscall_target <= wr_value;
        idx_write_handling_control: write_handling_control <= wr_value;
        idx_uncached_combining_control: uncached_combining_control <= wr_value;
        idx_power_mgmt_base: power_mgmt_base <= wr_value;
        idx_state_observability: state_observability <= wr_value;
        idx_page_flush_invalidate: page_flush_invalidate <= wr_value;
        idx_second_level_array_access: second_level_array_access <= wr_value;
        default: ;
      endcase
    end
  end

  // Answer path; counter instruction shares it, so only one may run a cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      msr_rsp <= '0;
    end else begin
      msr_rsp.done <= msr_req.rd || msr_req.wr || counter_read_instr;
      msr_rsp.fault <= 1'b0;
      msr_rsp.low_data <= reg32_reset;
      msr_rsp.high_data <= reg32_reset;
      if (counter_read_instr) begin
        // disable bit limits counter read to level 0
        if (control_register_four[counter_disable_pos] && counter_privilege != 2'b00) begin
          msr_rsp.fault <= 1'b1;
        end else begin
          msr_rsp.high_data <= cycle_counter[63:32];
          msr_rsp.low_data <= cycle_counter[31:0];
        end
      end else if (msr_req.rd || msr_req.wr) begin
        // faults for level, index or reserved bits
        if (!priv_ok || !known || bad_reserved) begin
          msr_rsp.fault <= 1'b1;
        end else if (msr_req.rd) begin
          // read answer on the data registers
          msr_rsp.high_data <= next_read[63:32];
          msr_rsp.low_data <= next_read[31:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        breakpoint_addr[i] <= reg32_reset;
      end
    end else if (dbg_req.wr && dbg_req.num <= dbg_breakpoint_three) begin
      breakpoint_addr[dbg_req.num[1:0]] <= dbg_req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dbg_rdata <= reg32_reset;
      dbg_done <= 1'b0;
    end else begin
      dbg_done <= dbg_req.rd || dbg_req.wr;
      // positions four and five read zero
      if (dbg_req.rd && dbg_req.num <= dbg_breakpoint_three) begin
        dbg_rdata <= breakpoint_addr[dbg_req.num[1:0]];
      end else begin
        dbg_rdata <= reg32_reset;
      end
    end
  end

  // cache disable control; exception never raised
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      l1_cache_disable <= 1'b0;
      machine_check_exception <= 1'b0;
      feature_enable_out <= feature_enable_reset;
    end else begin
      l1_cache_disable <= cache_disable_test[cache_disable_bit];
      machine_check_exception <= 1'b0;
      feature_enable_out <= feature_enable;
    end
  end

endmodule

//--- logic/msr_bank_pkg.sv
// Constants and carrier types for the model-specific register bank.
// Assumes a single processor clock and a synchronous active-low reset.
package msr_bank_pkg;

  // Register indices as held in the index general register
  localparam logic [31:0] idx_machine_check_address = 32'h0000_0000;
  localparam logic [31:0] idx_machine_check_type = 32'h0000_0001;
  localparam logic [31:0] idx_cache_disable_test = 32'h0000_000e;
  localparam logic [31:0] idx_cycle_counter = 32'h0000_0010;
  localparam logic [31:0] idx_feature_enable = 32'hc000_0080;
  localparam logic [31:0] idx_syscall_target = 32'hc000_0081;
  localparam logic [31:0] idx_write_handling_control = 32'hc000_0082;
  localparam logic [31:0] idx_uncached_combining_control = 32'hc000_0085;
  localparam logic [31:0] idx_power_mgmt_base = 32'hc000_0086;
  localparam logic [31:0] idx_state_observability = 32'hc000_0087;
  localparam logic [31:0] idx_page_flush_invalidate = 32'hc000_0088;
  localparam logic [31:0] idx_second_level_array_access = 32'hc000_0089;

  // Debug register positions (3-bit register number)
  localparam logic [2:0] dbg_breakpoint_zero = 3'h0;
  localparam logic [2:0] dbg_breakpoint_three = 3'h3;
  localparam logic [2:0] dbg_reserved_four = 3'h4;
  localparam logic [2:0] dbg_reserved_five = 3'h5;

  // Feature enable: bits 4..0 implemented, 63..5 reserved
  localparam logic [63:0] feature_enable_impl_mask = 64'h0000_0000_0000_001f;
  localparam logic [63:0] feature_enable_reset = 64'h0000_0000_0000_0002;
  // Cache disable control bit position in the test register
  localparam int cache_disable_bit = 3;
  // Control register four bit positions
  localparam int counter_disable_pos = 2;
  localparam int machine_check_enable_pos = 6;

  // Reset values
  localparam logic [63:0] reg64_reset = 64'h0000_0000_0000_0000;
  localparam logic [31:0] reg32_reset = 32'h0000_0000;

  // One register access request from the executing core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] index;
    logic [31:0] low_data;
    logic [31:0] high_data;
    logic [1:0] privilege;
  } msr_req_t;

  // Answer returned to the core
  typedef struct packed {
    logic done;
    logic fault;
    logic [31:0] low_data;
    logic [31:0] high_data;
  } msr_rsp_t;

  // Debug register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] num;
    logic [31:0] data;
  } dbg_req_t;

  typedef enum logic [1:0] {
    acc_none,
    acc_msr,
    acc_counter
  } acc_kind_t;

endpackage

//--- dv/msr_bank_checker.sv
// Port checks for the register bank.
// Assumes one clock domain and sight of the bank's ports only.
`timescale 1ns/1ps
module msr_bank_checker
  import msr_bank_pkg::*;
#(
  parameter bit low_power = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire msr_req_t msr_req,
  input wire logic counter_read_instr,
  input wire logic [1:0] counter_privilege,
  input wire logic [31:0] control_register_four,
  input wire dbg_req_t dbg_req,
  input wire msr_rsp_t msr_rsp,
  input wire logic [31:0] dbg_rdata,
  input wire logic dbg_done,
  input wire logic l1_cache_disable,
  input wire logic machine_check_exception,
  input wire logic [63:0] feature_enable_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic cnt_acc;
  logic cnt_rd;
  assign req = msr_req.rd | msr_req.wr;
  assign cnt_acc = msr_req.index == idx_cycle_counter && msr_req.privilege == 2'h0 && !counter_read_instr;
  assign cnt_rd = counter_read_instr && !control_register_four[counter_disable_pos] && !msr_req.wr;
  a_answer_next: assert property ((req | counter_read_instr) |=> msr_rsp.done)
    else $error("no answer after request");
  a_no_mc_exception: assert property (!machine_check_exception)
    else $error("machine check raised");
  a_priv_fault: assert property (req && msr_req.privilege != 2'h0 && !counter_read_instr |=> msr_rsp.fault)
    else $error("privileged access not refused");
  a_reserved_fault: assert property (msr_req.wr && msr_req.index == idx_feature_enable
    && {msr_req.high_data, msr_req.low_data[31:5]} != 59'h0 |=> msr_rsp.fault) else $error("reserved bit accepted");
  a_power_absent: assert property (!low_power && req && msr_req.index == idx_power_mgmt_base |=> msr_rsp.fault)
    else $error("absent register accepted");
  a_counter_load: assert property ((msr_req.wr && cnt_acc) ##1 (msr_req.rd && cnt_acc)
    |=> {msr_rsp.high_data, msr_rsp.low_data} == $past({msr_req.high_data, msr_req.low_data}, 2)) else $error("load lost");
  a_counter_step: assert property (cnt_rd ##1 cnt_rd
    |=> {msr_rsp.high_data, msr_rsp.low_data} == $past({msr_rsp.high_data, msr_rsp.low_data}) + 64'h1)
    else $error("counter step wrong");
  a_dbg_reserved: assert property (dbg_req.rd && dbg_req.num[2] |=> dbg_done && dbg_rdata == 32'h0)
    else $error("reserved debug read nonzero");
endmodule
bind msr_bank msr_bank_checker #(.low_power(low_power)) chk_u (.core_clk(core_clk), .rst_n(rst_n), .msr_req(msr_req),
  .counter_read_instr(counter_read_instr), .counter_privilege(counter_privilege),
  .control_register_four(control_register_four), .dbg_req(dbg_req), .msr_rsp(msr_rsp), .dbg_rdata(dbg_rdata),
  .dbg_done(dbg_done), .l1_cache_disable(l1_cache_disable), .machine_check_exception(machine_check_exception),
  .feature_enable_out(feature_enable_out));

//--- dv/core_model.sv
// Executing core that issues register, counter and debug instructions.
// Assumes the bank takes a request at the edge after it is driven.
`timescale 1ns/1ps
module core_model
  import msr_bank_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Requests
  output msr_req_t msr_req,
  output logic counter_read_instr,
  output logic [1:0] counter_privilege,
  output logic [31:0] control_register_four,
  output dbg_req_t dbg_req
);
  initial begin
    msr_req = '0;
    counter_read_instr = 1'b0;
    counter_privilege = 2'h0;
    control_register_four = 32'h0;
    dbg_req = '0;
  end
  // Kind 0 idle, 1 register, 2 counter read (idx sets control four), 3 debug
  // Idle fields flip so stale data never passes for valid
  task automatic issue(input int kind, input logic rd, input logic [31:0] idx, input logic [63:0] v,
    input logic [1:0] pl);
    @(posedge core_clk);
    msr_req <= (kind == 1) ? msr_req_t'({rd, !rd, idx, v[31:0], v[63:32], pl}) : msr_req_t'({2'b00, ~msr_req[97:0]});
    counter_read_instr <= (kind == 2);
    counter_privilege <= pl;
    if (kind == 2) begin
      control_register_four <= idx;
    end
    dbg_req <= (kind == 3) ? dbg_req_t'({rd, !rd, idx[2:0], v[31:0]}) : dbg_req_t'({2'b00, ~dbg_req[34:0]});
  endtask
endmodule

//--- dv/model_specific_register_bank_test.sv
// Self-checking bench: reference model of the bank compared at every answer.
// Assumes the standard-power variant driven by the core model.
`timescale 1ns/1ps
module model_specific_register_bank_test;
  import msr_bank_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  msr_req_t msr_req;
  logic counter_read_instr;
  logic [1:0] counter_privilege;
  logic [31:0] control_register_four;
  dbg_req_t dbg_req;
  msr_rsp_t msr_rsp;
  msr_rsp_t exp_rsp;
  logic [31:0] dbg_rdata;
  logic [31:0] exp_dbg;
  logic dbg_done;
  logic l1_cache_disable;
  logic machine_check_exception;
  logic [63:0] feature_enable_out;
  logic [63:0] regs [logic [31:0]];
  logic [63:0] counter_m;
  logic [63:0] rv;
  logic [31:0] dbg_m [8];
  logic ok, flt, pend, dpend;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 6;
  // First eleven exist; the rest must be refused
  logic [31:0] all_idx [15] = '{idx_machine_check_address, idx_machine_check_type, idx_cache_disable_test,
    idx_cycle_counter, idx_feature_enable, idx_syscall_target, idx_write_handling_control,
    idx_uncached_combining_control, idx_state_observability, idx_page_flush_invalidate,
    idx_second_level_array_access, idx_power_mgmt_base, 32'h0000_0002, 32'hc000_0083, 32'hffff_ffff};
  always #20 core_clk = ~core_clk;
  msr_bank #(.low_power(1'b0)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .msr_req(msr_req),
    .counter_read_instr(counter_read_instr), .counter_privilege(counter_privilege),
    .control_register_four(control_register_four), .dbg_req(dbg_req), .msr_rsp(msr_rsp), .dbg_rdata(dbg_rdata),
    .dbg_done(dbg_done), .l1_cache_disable(l1_cache_disable), .machine_check_exception(machine_check_exception),
    .feature_enable_out(feature_enable_out));
  core_model core_u (.core_clk(core_clk), .msr_req(msr_req), .counter_read_instr(counter_read_instr),
    .counter_privilege(counter_privilege), .control_register_four(control_register_four), .dbg_req(dbg_req));
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset();
    core_u.issue(0, 1'b0, 32'h0, 64'h0, 2'h0);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic sweep();
    for (int i = 0; i < 15; i++) begin
      core_u.issue(1, 1'b1, all_idx[i], 64'h0, 2'h0);
    end
    core_u.issue(0, 1'b0, 32'h0, 64'h0, 2'h0);
  endtask
  always @(posedge core_clk) begin
    pend <= msr_req.rd | msr_req.wr | counter_read_instr;
    dpend <= dbg_req.rd | dbg_req.wr;
    if (!rst_n) begin
      // reset clears all but feature enable
      for (int i = 0; i < 11; i++) begin
        regs[all_idx[i]] = (i == 4) ? feature_enable_reset : reg64_reset;
      end
      counter_m = reg64_reset;
      foreach (dbg_m[i]) dbg_m[i] = reg32_reset;
    end else begin
      ok = regs.exists(msr_req.index) && msr_req.privilege == 2'h0 && !(msr_req.wr
        && msr_req.index == idx_feature_enable && ({msr_req.high_data, msr_req.low_data} & ~feature_enable_impl_mask) != 0);
      rv = !ok ? 64'h0 : (msr_req.index == idx_cycle_counter) ? counter_m : regs[msr_req.index];
      flt = control_register_four[counter_disable_pos] && counter_privilege != 2'h0;
      exp_rsp <= counter_read_instr ? msr_rsp_t'({1'b1, flt, flt ? 64'h0 : {counter_m[31:0], counter_m[63:32]}})
        : msr_rsp_t'({1'b1, !ok, msr_req.rd ? {rv[31:0], rv[63:32]} : 64'h0});
      exp_dbg <= (dbg_req.rd && !dbg_req.num[2]) ? dbg_m[dbg_req.num] : 32'h0;
      counter_m = counter_m + 64'h1;
      if (ok && msr_req.wr) begin
        regs[msr_req.index] = {msr_req.high_data, msr_req.low_data};
        counter_m = (msr_req.index == idx_cycle_counter) ? regs[msr_req.index] : counter_m;
      end
      if (dbg_req.wr && !dbg_req.num[2]) dbg_m[dbg_req.num] = dbg_req.data;
    end
  end
  always @(negedge core_clk) begin
    if (rst_n) begin
      check(msr_rsp, pend ? exp_rsp : 66'h0);
      if (dpend) check({dbg_done, dbg_rdata}, {1'b1, exp_dbg});
    end
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
  initial begin
    do_reset();
    sweep();
    for (int i = 0; i < 15; i++) core_u.issue(1, 1'b0, all_idx[i], {$random(seed), $random(seed)}, 2'h0);
    core_u.issue(1, 1'b0, idx_feature_enable, {59'h0, 5'($random(seed))}, 2'h0);
    core_u.issue(1, 1'b0, idx_cache_disable_test, 64'h8, 2'h0);
    for (int p = 1; p < 4; p++) core_u.issue(1, p[0], idx_machine_check_address, 64'h5a, 2'(p));
    sweep();
    core_u.issue(1, 1'b0, idx_cycle_counter, 64'hffff_ffff_ffff_fffe, 2'h0);
    core_u.issue(1, 1'b1, idx_cycle_counter, 64'h0, 2'h0);
    for (int k = 0; k < 6; k++) core_u.issue(2, 1'b1, (k < 3) ? 32'h0 : 32'h44, 64'h0, 2'(k));
    for (int n = 0; n < 16; n++) core_u.issue(3, n[3], 32'(n), {$random(seed), $random(seed)}, 2'h0);
    repeat (3) core_u.issue(0, 1'b0, 32'h0, 64'h0, 2'h0);
    #1;
    check(66'(l1_cache_disable), 66'(regs[idx_cache_disable_test][cache_disable_bit]));
    check(66'(feature_enable_out), 66'(regs[idx_feature_enable]));
    do_reset();
    sweep();
    test_done();
  end
endmodule
